// ==== hdl/ddac_top.v ====
// Dual converter control, trigger selection and output data transfer.
// Assumes an APB master on I_REF_CLK, trigger sources from timers or pins,
// and DMA underrun flags from logic on the same clock.
`include "ddac_map.vh"
`default_nettype none
module ddac_top #(
  parameter HIGH_DENSITY = 1
) (
  input wire I_REF_CLK,
  input wire I_RESET_N,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire [3:0] I_PSTRB,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  input wire I_TIM6_TRG,
  input wire I_TIM3_TRG,
  input wire I_TIM7_TRG,
  input wire I_TIM5_TRG,
  input wire I_TIM15_TRG,
  input wire I_TIM2_TRG,
  input wire I_TIM4_TRG,
  input wire I_EXT_LINE9,
  input wire I_TRIGGER3_REMAP,
  input wire I_CH1_DMA_UNDERRUN,
  input wire I_CH2_DMA_UNDERRUN,
  output wire O_CH1_CHANNEL_ON,
  output wire O_CH1_BUFFER_OFF,
  output wire O_CH1_DMA_MODE,
  output wire O_CH1_UNDERRUN_IRQ,
  output wire [11:0] O_CH1_OUTPUT_DATA,
  output wire O_CH2_CHANNEL_ON,
  output wire O_CH2_BUFFER_OFF,
  output wire O_CH2_DMA_MODE,
  output wire O_CH2_UNDERRUN_IRQ,
  output wire [11:0] O_CH2_OUTPUT_DATA
);

  localparam integer PIPE = `DDAC_HW_DELAY - 1;

  // ----------------------------------------------------------------
  // Bus slave state
  // ----------------------------------------------------------------
  reg [31:0] ctrl_r;
  reg [31:0] prdata_r;
  reg [31:0] prdata_nxt;
  reg pready_r;
  reg pslverr_r;
  reg err_nxt;
  reg [1:0] irq_r;
  wire setup;
  wire acc_ok;
  wire wr_acc;
  wire [23:0] hold_all;
  wire [23:0] out_all;

  // ----------------------------------------------------------------
  // Trigger inputs
  // ----------------------------------------------------------------
  wire [8:0] trg_level;
  wire [8:0] trg_rise;
  wire src3_rise;
  wire [7:0] src_rise;

  // Synchronised sources and remap level
  ddac_trig_sync #(
    .W(9)
  ) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RESET_N),
    .i_async({I_TRIGGER3_REMAP, I_EXT_LINE9, I_TIM4_TRG, I_TIM2_TRG,
              I_TIM15_TRG, I_TIM5_TRG, I_TIM7_TRG, I_TIM3_TRG, I_TIM6_TRG}),
    .o_level(trg_level),
    .o_rise(trg_rise)
  );

  // Source 3 from timer 15 or timer 5
  assign src3_rise = (HIGH_DENSITY != 0) ?
                     (trg_level[8] ? trg_rise[4] : trg_rise[3]) :
                     trg_rise[4]; // RL7

  // Edge pulses indexed by source code; code 7 has no hardware source
  assign src_rise = {1'b0, trg_rise[7], trg_rise[6], trg_rise[5],
                     src3_rise, trg_rise[2], trg_rise[1], trg_rise[0]}; // RL6

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup = I_PSEL & ~I_PENABLE;
  assign acc_ok = I_PSEL & I_PENABLE & pready_r & ~pslverr_r;
  assign wr_acc = acc_ok & I_PWRITE;

  // Read data and error for the address in the setup cycle
  always @*
  begin
    prdata_nxt = 32'h00000000;
    err_nxt = 1'b0;
    case (I_PADDR)
      `DDAC_OFF_CTRL:
        prdata_nxt = ctrl_r;
      `DDAC_OFF_SWTRIG:
        prdata_nxt = 32'h00000000; // RL15
      `DDAC_OFF_HOLD1:
        prdata_nxt = {20'h00000, hold_all[11:0]};
      `DDAC_OFF_HOLD2:
        prdata_nxt = {20'h00000, hold_all[23:12]};
      `DDAC_OFF_HOLDD:
        prdata_nxt = {4'h0, hold_all[23:12], 4'h0, hold_all[11:0]};
      `DDAC_OFF_OUT1:
        prdata_nxt = {20'h00000, out_all[11:0]};
      `DDAC_OFF_OUT2:
        prdata_nxt = {20'h00000, out_all[23:12]};
      default:
        err_nxt = 1'b1;
    endcase
    if (I_PWRITE && (I_PSTRB != `DDAC_FULL_STRB))
      err_nxt = 1'b1; // RL1
    if (!I_PWRITE && (I_PADDR == `DDAC_OFF_OUT1 || I_PADDR == `DDAC_OFF_OUT2))
      err_nxt = err_nxt;
    if (I_PWRITE && (I_PADDR == `DDAC_OFF_OUT1 || I_PADDR == `DDAC_OFF_OUT2))
      err_nxt = 1'b1;
    if (I_PWRITE)
      prdata_nxt = 32'h00000000;
  end

  // Ready, error and read data, registered in the setup cycle
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= setup;
      if (setup)
      begin
        pslverr_r <= err_nxt;
        prdata_r <= prdata_nxt;
      end
      else if (pready_r)
      begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      ctrl_r <= `DDAC_CTRL_RST;
    else if (wr_acc && (I_PADDR == `DDAC_OFF_CTRL))
      ctrl_r <= I_PWDATA & `DDAC_CTRL_MASK; // RL2
  end

  // Underrun interrupt gated by mode and allow bits
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      irq_r <= 2'b00;
    else
    begin
      irq_r[0] <= I_CH1_DMA_UNDERRUN & ctrl_r[`DDAC_F_DMA] &
                  ctrl_r[`DDAC_F_UDRIE]; // RL14
      irq_r[1] <= I_CH2_DMA_UNDERRUN & ctrl_r[`DDAC_CH2_SHIFT + `DDAC_F_DMA] &
                  ctrl_r[`DDAC_CH2_SHIFT + `DDAC_F_UDRIE]; // RL14
    end
  end

  // ----------------------------------------------------------------
  // Per-channel transfer logic
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : ch
      localparam integer B = g * `DDAC_CH2_SHIFT;
      wire ten;
      wire [2:0] tsel;
      wire [1:0] wave;
      wire [3:0] mamp;
      wire [11:0] gen_val;
      wire hold_single;
      wire hold_wr;
      wire [11:0] hold_din;
      wire swt_set;
      wire sw_sel;
      wire sw_fire;
      wire hw_fire;
      wire load;
      wire step;
      reg [11:0] hold_r;
      reg [11:0] out_r;
      reg wr_pend_r;
      reg [PIPE-1:0] hw_pipe_r;
      reg swt_r;
      reg sw_done_r;

      // Field extraction; wave and source gated by trigger enable
      assign ten = ctrl_r[B + `DDAC_F_TEN];
      assign tsel = ctrl_r[B + `DDAC_F_TSEL_HI:B + `DDAC_F_TSEL_LO];
      assign wave = ten ? ctrl_r[B + `DDAC_F_WAVE_HI:B + `DDAC_F_WAVE_LO] :
                    `DDAC_WAVE_OFF; // RL5
      assign mamp = ctrl_r[B + `DDAC_F_MAMP_HI:B + `DDAC_F_MAMP_LO];

      // Holding data writes from single or dual registers
      assign hold_single = (I_PADDR == ((g == 0) ? `DDAC_OFF_HOLD1 :
                                                   `DDAC_OFF_HOLD2));
      assign hold_wr = wr_acc & (hold_single | (I_PADDR == `DDAC_OFF_HOLDD));
      assign hold_din = hold_single ? I_PWDATA[11:0] : I_PWDATA[B + 11:B];

      // Software trigger request bit of this channel
      assign swt_set = wr_acc & (I_PADDR == `DDAC_OFF_SWTRIG) & I_PWDATA[g]; // RL15

      // Transfer conditions
      assign sw_sel = ten & (tsel == `DDAC_TSEL_SW);
      assign sw_fire = sw_sel & swt_r & ~sw_done_r; // RL10
      assign hw_fire = ten & ~sw_sel & hw_pipe_r[PIPE-1]; // RL9
      assign load = (~ten & wr_pend_r) | hw_fire | sw_fire; // RL8
      assign step = load & (wave != `DDAC_WAVE_OFF); // RL17

      // Noise and triangle source
      ddac_wave_gen u_gen (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RESET_N),
        .i_step(step),
        .i_wave(wave),
        .i_mamp(mamp),
        .o_value(gen_val)
      );

      // Holding, output data and trigger sequencing
      always @(posedge I_REF_CLK or negedge I_RESET_N)
      begin
        if (!I_RESET_N)
        begin
          hold_r <= 12'h000;
          out_r <= 12'h000;
          wr_pend_r <= 1'b0;
          hw_pipe_r <= {PIPE{1'b0}};
          swt_r <= `DDAC_SWT_RST;
          sw_done_r <= 1'b0;
        end
        else
        begin
          if (hold_wr)
            hold_r <= hold_din;
          wr_pend_r <= hold_wr & ~ten; // RL8
          hw_pipe_r <= {hw_pipe_r[PIPE-2:0],
                        src_rise[tsel] & ten & ~sw_sel}; // RL9
          if (load)
            out_r <= hold_r + gen_val; // RL17
          sw_done_r <= sw_fire;
          if (swt_set)
            swt_r <= 1'b1; // RL15
          else if (sw_done_r)
            swt_r <= 1'b0; // RL16
        end
      end

      assign hold_all[12*g + 11:12*g] = hold_r;
      assign out_all[12*g + 11:12*g] = out_r;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_CH1_CHANNEL_ON = ctrl_r[`DDAC_F_ON]; // RL12
  assign O_CH1_BUFFER_OFF = ctrl_r[`DDAC_F_BOFF]; // RL11
  assign O_CH1_DMA_MODE = ctrl_r[`DDAC_F_DMA]; // RL13
  assign O_CH1_UNDERRUN_IRQ = irq_r[0];
  assign O_CH1_OUTPUT_DATA = out_all[11:0];
  assign O_CH2_CHANNEL_ON = ctrl_r[`DDAC_CH2_SHIFT + `DDAC_F_ON]; // RL12
  assign O_CH2_BUFFER_OFF = ctrl_r[`DDAC_CH2_SHIFT + `DDAC_F_BOFF]; // RL11
  assign O_CH2_DMA_MODE = ctrl_r[`DDAC_CH2_SHIFT + `DDAC_F_DMA]; // RL13
  assign O_CH2_UNDERRUN_IRQ = irq_r[1];
  assign O_CH2_OUTPUT_DATA = out_all[23:12];

endmodule
`default_nettype wire

// ==== hdl/ddac_map.vh ====
// Register map, field positions, reset values and timing counts of the
// dual converter control block.
// Assumes inclusion by bare name from every design file that needs it.
//
// Functional notes
// RL1: Software uses full 32-bit word accesses only
// RL2: Control fields per channel, channel2 sixteen bits up
// RL3: Mask code n unmasks bits n..0, amplitude 2^(n+1)-1
// RL4: Wave 00 off, 01 noise, 1x triangle
// RL5: Source and wave honoured only with trigger on
// RL6: Source codes map timers, line 9, software
// RL7: Source 3 follows remap on larger parts
// RL8: Trigger off: holding to output one cycle
// RL9: Hardware trigger: holding to output three cycles
// RL10: Software trigger: transfer takes one cycle
// RL11: Buffer-off bit disables output buffer when set
// RL12: Channel-on bit switches channel on
// RL13: DMA bit puts channel in DMA mode
// RL14: Underrun interrupt passes only when allowed
// RL15: Write-only software trigger bits 0 and 1
// RL16: Trigger bit self-clears one cycle after load
// RL17: Wave value added to holding data, then advanced
// RL18: Hardware sources edge-detected, one event one transfer
// RL19: Triangle up to amplitude and down; sum wraps
`ifndef DDAC_MAP_VH
`define DDAC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DDAC_OFF_CTRL 8'h00
`define DDAC_OFF_SWTRIG 8'h04
`define DDAC_OFF_HOLD1 8'h08
`define DDAC_OFF_HOLD2 8'h14
`define DDAC_OFF_HOLDD 8'h20
`define DDAC_OFF_OUT1 8'h2c
`define DDAC_OFF_OUT2 8'h30

// ----------------------------------------------------------------
// Control field positions, channel1; channel2 adds the shift
// ----------------------------------------------------------------
`define DDAC_F_ON 0
`define DDAC_F_BOFF 1
`define DDAC_F_TEN 2
`define DDAC_F_TSEL_LO 3
`define DDAC_F_TSEL_HI 5
`define DDAC_F_WAVE_LO 6
`define DDAC_F_WAVE_HI 7
`define DDAC_F_MAMP_LO 8
`define DDAC_F_MAMP_HI 11
`define DDAC_F_DMA 12
`define DDAC_F_UDRIE 13
`define DDAC_CH2_SHIFT 16

// ----------------------------------------------------------------
// Reset values, masks and codes
// ----------------------------------------------------------------
`define DDAC_CTRL_RST 32'h00000000
`define DDAC_CTRL_MASK 32'h3fff3fff
`define DDAC_SWT_RST 1'b0
`define DDAC_TSEL_SW 3'h7
`define DDAC_WAVE_OFF 2'h0
`define DDAC_WAVE_NOISE 2'h1
`define DDAC_MAMP_FULL 4'hb
`define DDAC_LFSR_SEED 12'haaa
`define DDAC_FULL_STRB 4'hf

// ----------------------------------------------------------------
// Transfer latencies in clock cycles
// ----------------------------------------------------------------
`define DDAC_HW_DELAY 3
`define DDAC_DIRECT_DELAY 1
`define DDAC_SW_DELAY 1

`endif

// ==== hdl/ddac_trig_sync.v ====
// Two-stage synchroniser and rising-edge detector for trigger inputs.
// Assumes inputs may come from any domain; outputs are on i_clk.
`default_nettype none
module ddac_trig_sync #(
  parameter W = 9
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_level,
  output wire [W-1:0] o_rise
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] rise_r;

  // ----------------------------------------------------------------
  // Synchroniser, delay stage and edge pulse
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      rise_r <= {W{1'b0}};
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise_r <= s2_r & ~s3_r; // RL18
    end
  end

  assign o_level = s2_r;
  assign o_rise = rise_r;

endmodule
`default_nettype wire

// ==== hdl/ddac_wave_gen.v ====
// Noise and triangle generator for one converter channel.
// Assumes i_step is a one-cycle pulse given in the same cycle as each triggered load.
`include "ddac_map.vh"
`default_nettype none
module ddac_wave_gen (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_step,
  input wire [1:0] i_wave,
  input wire [3:0] i_mamp,
  output wire [11:0] o_value
);

  reg [11:0] lfsr_r;
  reg [11:0] tri_r;
  reg up_r;
  wire [12:0] mask_full;
  wire [11:0] mask;
  wire fb;

  // Mask and amplitude from the code, saturating at 12 bits
  assign mask_full = (13'h0002 << i_mamp) - 13'h0001; // RL3
  assign mask = (i_mamp >= `DDAC_MAMP_FULL) ? 12'hfff : mask_full[11:0]; // RL3
  assign fb = lfsr_r[11] ^ lfsr_r[5] ^ lfsr_r[3] ^ lfsr_r[0];

  // ----------------------------------------------------------------
  // Generators advance only on a step in their own mode
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lfsr_r <= `DDAC_LFSR_SEED;
      tri_r <= 12'h000;
      up_r <= 1'b1;
    end
    else if (i_step)
    begin
      if (i_wave == `DDAC_WAVE_NOISE)
        lfsr_r <= {lfsr_r[10:0], fb}; // RL17
      else if (i_wave[1])
      begin
        if (up_r && (tri_r >= mask))
        begin
          up_r <= 1'b0; // RL19
          tri_r <= tri_r - 12'h001;
        end
        else if (up_r)
          tri_r <= tri_r + 12'h001; // RL19
        else if (tri_r == 12'h000)
        begin
          up_r <= 1'b1; // RL19
          tri_r <= 12'h001;
        end
        else
          tri_r <= tri_r - 12'h001;
      end
    end
  end

  // Masked noise, triangle count or nothing
  assign o_value = (i_wave == `DDAC_WAVE_NOISE) ? (lfsr_r & mask) :
                   i_wave[1] ? tri_r : 12'h000; // RL4

endmodule
`default_nettype wire

// ==== testbench/ddct_trig_src.sv ====
// Timer and pin trigger sources for the converter control block.
// Assumes the bench calls fire(); lines idle low between events.
`default_nettype none
module ddct_trig_src (
  input wire logic i_clk,
  output logic [7:0] o_trg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_trg = 8'h00;
  // Raise one source for n cycles, then drop it
  task automatic fire(input int i, input int n);
    @(posedge i_clk);
    o_trg[i] <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_trg[i] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== testbench/ddct_checker.sv ====
// Port-level checks for the dual converter control block.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module ddct_checker (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_CH1_DMA_UNDERRUN,
  input wire logic I_CH2_DMA_UNDERRUN,
  input wire logic O_CH1_CHANNEL_ON,
  input wire logic O_CH1_BUFFER_OFF,
  input wire logic O_CH1_DMA_MODE,
  input wire logic O_CH1_UNDERRUN_IRQ,
  input wire logic [11:0] O_CH1_OUTPUT_DATA,
  input wire logic O_CH2_CHANNEL_ON,
  input wire logic O_CH2_BUFFER_OFF,
  input wire logic O_CH2_DMA_MODE,
  input wire logic O_CH2_UNDERRUN_IRQ
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic ch1_trigger_on_r;
  wire logic wr_ok;
  assign wr_ok = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && !O_PSLVERR;
  // Shadow of channel1 trigger-on bit
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      ch1_trigger_on_r <= 1'b0;
    else if (wr_ok && I_PADDR == 8'h00)
      ch1_trigger_on_r <= I_PWDATA[2];
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  a_ready_single: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  a_strobe_refused: assert property (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY
    && I_PSTRB != 4'hf |-> O_PSLVERR) else $error("partial write accepted");
  a_ro_refused: assert property (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY
    && I_PADDR == 8'h2c |-> O_PSLVERR) else $error("output data written");
  a_ctrl_bits: assert property (wr_ok && I_PADDR == 8'h00 |=>
    O_CH1_CHANNEL_ON == $past(I_PWDATA[0]) && O_CH1_BUFFER_OFF == $past(I_PWDATA[1])
    && O_CH2_CHANNEL_ON == $past(I_PWDATA[16]) && O_CH2_BUFFER_OFF == $past(I_PWDATA[17]))
    else $error("control bits wrong");
  a_dma_bits: assert property (wr_ok && I_PADDR == 8'h00 |=>
    {O_CH2_DMA_MODE, O_CH1_DMA_MODE} == {$past(I_PWDATA[28]), $past(I_PWDATA[12])})
    else $error("dma bits wrong");
  a_irq1_gated: assert property (O_CH1_UNDERRUN_IRQ |->
    $past(I_CH1_DMA_UNDERRUN && O_CH1_DMA_MODE)) else $error("ch1 irq ungated");
  a_irq2_gated: assert property (O_CH2_UNDERRUN_IRQ |->
    $past(I_CH2_DMA_UNDERRUN && O_CH2_DMA_MODE)) else $error("ch2 irq ungated");
  a_direct_load: assert property (wr_ok && I_PADDR == 8'h08 && !ch1_trigger_on_r |->
    ##2 O_CH1_OUTPUT_DATA == $past(I_PWDATA[11:0], 2)) else $error("direct load late");
endmodule
bind ddac_top ddct_checker chk_u (.*);
`default_nettype wire

// ==== testbench/dual_dac_control_trigger_tb.sv ====
// Self-checking bench for the dual converter control block.
// Assumes an APB master here and a trigger source model beside it.
`default_nettype none
module dual_dac_control_trigger_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, pen, pwr, er, remap, ur1, ur2;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb;
  wire [31:0] prdata;
  wire pready, pslverr, on1, bo1, dm1, irq1, on2, bo2, dm2, irq2;
  wire [11:0] out1, out2;
  wire [7:0] trg;
  int miscompares, check_count;
  ddac_top dut_u (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TIM6_TRG(trg[0]), .I_TIM3_TRG(trg[1]), .I_TIM7_TRG(trg[2]), .I_TIM5_TRG(trg[3]),
    .I_TIM2_TRG(trg[4]), .I_TIM4_TRG(trg[5]), .I_EXT_LINE9(trg[6]), .I_TIM15_TRG(trg[7]),
    .I_TRIGGER3_REMAP(remap), .I_CH1_DMA_UNDERRUN(ur1), .I_CH2_DMA_UNDERRUN(ur2),
    .O_CH1_CHANNEL_ON(on1), .O_CH1_BUFFER_OFF(bo1), .O_CH1_DMA_MODE(dm1),
    .O_CH1_UNDERRUN_IRQ(irq1), .O_CH1_OUTPUT_DATA(out1), .O_CH2_CHANNEL_ON(on2),
    .O_CH2_BUFFER_OFF(bo2), .O_CH2_DMA_MODE(dm2), .O_CH2_UNDERRUN_IRQ(irq2),
    .O_CH2_OUTPUT_DATA(out2));
  ddct_trig_src src_u (.i_clk(clk), .o_trg(trg));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer, byte strobes from s, whole word by default
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20)
      miscompares++;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out;
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out;
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, psel, pen, pwr, remap, ur1, ur2} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 8'h00, 0); chk(rd, 32'h0);
    apb(1, 8'h00, 32'hffffffff); apb(0, 8'h00, 0); chk(rd, 32'h3fff3fff);
    chk({on1, bo1, dm1, on2, bo2, dm2}, 32'h3f);
    apb(0, 8'h04, 0); chk(rd, 32'h0);
    apb(1, 8'h00, 0, 4'h3); chk(er, 1); apb(0, 8'h00, 0); chk(rd, 32'h3fff3fff);
    apb(1, 8'h2c, 0); chk(er, 1); apb(0, 8'h3c, 0); chk(er, 1); chk(rd, 0);
    apb(1, 8'h00, 0); nx(1); chk({on1, bo1, dm1, on2, bo2, dm2}, 0);
    apb(1, 8'h08, 32'h123); nx(1); chk(out1, 0); nx(1); chk(out1, 32'h123);
    // Underrun interrupt gating
    ur1 <= 1'b1;
    ur2 <= 1'b1;
    apb(1, 8'h00, 32'h10001000); nx(2); chk({irq1, irq2}, 0);
    apb(1, 8'h00, 32'h30003000); nx(2); chk({irq1, irq2}, 3);
    ur1 <= 1'b0;
    ur2 <= 1'b0;
    nx(2); chk({irq1, irq2}, 0);
    // Software trigger on channel1
    apb(1, 8'h00, 32'h3c); apb(1, 8'h08, 32'h456); nx(3); chk(out1, 32'h123);
    apb(1, 8'h04, 1); nx(1); chk(out1, 32'h123); nx(1); chk(out1, 32'h456);
    apb(1, 8'h08, 32'h789); nx(2); chk(out1, 32'h456);
    apb(1, 8'h04, 1); nx(2); chk(out1, 32'h789);
    // Hardware sources on channel2
    for (int s = 0; s < 7; s++)
    begin
      apb(1, 8'h00, 32'h40000 | (s << 19));
      apb(1, 8'h14, 32'h100 + s);
      src_u.fire((s == 3) ? 7 : (s + 1) % 7, 3);
      nx(10); chk(out2, (s == 0) ? 0 : 32'hff + s);
      src_u.fire(s, 5);
      nx(10); chk(out2, 32'h100 + s);
    end
    remap <= 1'b1;
    apb(1, 8'h00, 32'h40000 | (3 << 19)); apb(1, 8'h14, 32'h222);
    src_u.fire(3, 3); nx(10); chk(out2, 32'h106);
    src_u.fire(7, 3); nx(10); chk(out2, 32'h222);
    // Triangle, amplitude 3, six source pulses
    apb(1, 8'h00, 32'h184); apb(1, 8'h08, 32'h100);
    for (int k = 0; k < 6; k++)
    begin
      src_u.fire(0, 6);
      nx(12); chk(out1, 32'h100 + ((k <= 3) ? k : 6 - k));
    end
    apb(1, 8'h00, 32'h180); apb(1, 8'h08, 32'h200); nx(2); chk(out1, 32'h200);
    // Noise with one unmasked bit; seed bit0 is clear
    apb(1, 8'h00, 32'h44); apb(1, 8'h08, 32'h300);
    src_u.fire(0, 3); nx(10); chk(out1, 32'h300);
    // Software trigger on channel2
    apb(1, 8'h00, 32'h3c0000); apb(1, 8'h14, 32'h5a5); nx(2); chk(out2, 32'h222);
    apb(1, 8'h04, 2); nx(2); chk(out2, 32'h5a5);
    // Dual holding write with both triggers off, then read-back
    apb(1, 8'h00, 0); apb(1, 8'h20, 32'h0abc0def); nx(2); chk(out1, 32'hdef);
    chk(out2, 32'habc);
    apb(0, 8'h20, 0); chk(rd, 32'h0abc0def);
    apb(0, 8'h2c, 0); chk(rd, 32'hdef); apb(0, 8'h30, 0); chk(rd, 32'habc);
    close_out;
  end
endmodule
`default_nettype wire
